// [core/lps_pkg.sv]
// Constants, types and counter helpers for the push-down stack.
// Notes on behaviour
// R01 - Stack holds up to 254 words of 4 bits, parallel in, parallel out.
// R02 - Data, read and write requests are sampled on the rising clock edge.
// R03 - Host keeps the stack clock at or below 15 MHz, 50% duty. The bench runs pclk at 125 MHz (8 ns period).
// R04 - Write only: input to output reg, output to holding, count up, store holding.
// R05 - Read only: internal read bus to output reg, holding kept, count down.
// R06 - Read bus comes from holding after a write-only cycle, else from memory.
// R07 - Read with write: input to output reg, holding and counter unchanged.
// R08 - No request: registers, counter and stored words stay unchanged.
// R09 - Output always shows the youngest written word not yet read.
// R10 - Four flags: full, almost full, empty, almost empty; almost warns one early.
// R11 - Host never writes when full and never reads when empty.
// R12 - Address counter is an up/down shift-register counter, non-binary sequence.
// R13 - Master reset clears counter, output, holding and pending write; stack empty.
// R14 - Empty is zero words, almost empty one, almost full 253, full 254.
package lps_pkg;

   localparam int unsigned LPS_WIDTH          = 4;
   localparam int unsigned LPS_DEPTH          = 254;
   localparam int unsigned LPS_AW             = 8;
   localparam int unsigned LPS_CLK_PERIOD_NS  = 8;
   localparam int unsigned LPS_HOST_CLK_MHZ   = 15;

   localparam logic [7:0]  LPS_SEED           = 8'h01;
   localparam logic [3:0]  LPS_DATA_RESET     = 4'h0;

   // Register map, byte addresses.
   localparam logic [11:0] LPS_OFF_CTRL       = 12'h000;
   localparam logic [11:0] LPS_OFF_STATUS     = 12'h004;
   localparam logic [11:0] LPS_OFF_DATA       = 12'h008;

   localparam int unsigned LPS_CTRL_EN_BIT    = 0;
   localparam int unsigned LPS_CTRL_SRST_BIT  = 1;
   localparam logic [1:0]  LPS_CTRL_RESET     = 2'h1;

   localparam int unsigned LPS_ST_FULL_BIT    = 0;
   localparam int unsigned LPS_ST_AFULL_BIT   = 1;
   localparam int unsigned LPS_ST_EMPTY_BIT   = 2;
   localparam int unsigned LPS_ST_AEMPTY_BIT  = 3;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] data;
   } lps_req_s;

   typedef struct packed {
      logic full;
      logic almost_full;
      logic empty;
      logic almost_empty;
   } lps_flags_s;

   // One step up of the shift-register counter (taps 8,6,5,4, 255-state cycle).
   function automatic logic [7:0] lps_up(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   // Exact inverse of lps_up, so the counter can walk back down.
   function automatic logic [7:0] lps_dn(input logic [7:0] t);
      return {t[0] ^ t[6] ^ t[5] ^ t[4], t[7:1]};
   endfunction

   function automatic logic [7:0] lps_at(input int unsigned n);
      logic [7:0] s;
      s = LPS_SEED;
      for (int unsigned i = 0; i < n; i++) begin
         s = lps_up(s);
      end
      return s;
   endfunction

   localparam logic [7:0]  LPS_POS_EMPTY      = lps_at(0);
   localparam logic [7:0]  LPS_POS_AEMPTY     = lps_at(1);
   localparam logic [7:0]  LPS_POS_AFULL      = lps_at(LPS_DEPTH - 1);
   localparam logic [7:0]  LPS_POS_FULL       = lps_at(LPS_DEPTH);

endpackage

// [core/lps_stack.sv]
// Push-down stack core with APB control and status registers.
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module lps_stack (
   // Clock, reset, enable
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              ce,
   // APB slave
   input  wire logic [11:0]       paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Stack side
   input  wire logic              master_reset,
   input  wire lps_pkg::lps_req_s req,
   output logic [3:0]             q,
   output lps_pkg::lps_flags_s    flags
);
   import lps_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   logic [LPS_WIDTH-1:0] mem [0:(1<<LPS_AW)-1];
   logic [3:0]           q_r;
   logic [3:0]           q_nxt;
   logic [3:0]           hold_r;
   logic [3:0]           hold_nxt;
   logic [7:0]           addr_r;
   logic [7:0]           addr_nxt;
   logic                 pend_r;
   logic                 pend_nxt;
   logic [1:0]           ctrl_r;
   logic [1:0]           ctrl_nxt;
   logic [31:0]          prdata_r;
   logic [31:0]          prdata_nxt;
   logic                 go_wr;
   logic                 go_rd;
   logic                 clr;
   logic                 bus_wr;
   logic                 hit;
   logic [3:0]           rd_bus;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode. Requests are same-clock logic and need no synchroniser.
   assign hit    = (paddr == LPS_OFF_CTRL) || (paddr == LPS_OFF_STATUS)
                   || (paddr == LPS_OFF_DATA);
   assign pready = ce;
   assign pslverr = psel && penable && !hit;
   assign bus_wr = psel && penable && pwrite && ce && (paddr == LPS_OFF_CTRL);
   assign prdata = prdata_r;

   // Soft reset from the control register acts exactly like master reset.
   assign clr   = master_reset || (bus_wr && pwdata[LPS_CTRL_SRST_BIT]);
   assign go_wr = req.wr && ctrl_r[LPS_CTRL_EN_BIT] && !clr;  // see R02
   assign go_rd = req.rd && ctrl_r[LPS_CTRL_EN_BIT] && !clr;  // see R02

   // The word a push displaced from the output last cycle still sits in holding, its memory copy lands now.
   assign rd_bus = pend_r ? hold_r : mem[addr_r];  // see R06

   always_comb begin
      ctrl_nxt   = ctrl_r;
      prdata_nxt = prdata_r;
      if (bus_wr) begin
         ctrl_nxt = {1'b0, pwdata[LPS_CTRL_EN_BIT]};
      end
      if (psel && !penable) begin
         prdata_nxt = 32'h0000_0000;
         case (paddr)
            LPS_OFF_CTRL:   prdata_nxt[LPS_CTRL_EN_BIT] = ctrl_r[LPS_CTRL_EN_BIT];
            LPS_OFF_STATUS: prdata_nxt[3:0] = {flags.almost_empty, flags.empty,
                                               flags.almost_full, flags.full};
            LPS_OFF_DATA:   prdata_nxt[3:0] = q_r;
            default:        prdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Stack datapath.
   always_comb begin
      q_nxt    = q_r;
      hold_nxt = hold_r;
      addr_nxt = addr_r;
      pend_nxt = 1'b0;
      if (clr) begin  // see R13
         q_nxt    = LPS_DATA_RESET;
         hold_nxt = LPS_DATA_RESET;
         addr_nxt = LPS_POS_EMPTY;
      end else if (go_wr && !go_rd) begin  // see R04
         q_nxt    = req.data;
         hold_nxt = q_r;
         addr_nxt = lps_up(addr_r);  // see R12
         pend_nxt = 1'b1;
      end else if (go_rd && !go_wr) begin  // see R05
         q_nxt    = rd_bus;
         addr_nxt = lps_dn(addr_r);  // see R12
      end else if (go_rd && go_wr) begin  // see R07
         q_nxt    = req.data;
      end
      // Otherwise nothing moves. see R08
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_r      <= 4'h0;
         hold_r   <= 4'h0;
         addr_r   <= LPS_POS_EMPTY;
         pend_r   <= 1'b0;
         ctrl_r   <= LPS_CTRL_RESET;
         prdata_r <= 32'h0000_0000;
      end else if (ce) begin
         q_r      <= q_nxt;
         hold_r   <= hold_nxt;
         addr_r   <= addr_nxt;
         pend_r   <= pend_nxt;
         ctrl_r   <= ctrl_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   // The delayed store of holding replaces the clock-low write of the original.
   always_ff @(posedge pclk) begin
      if (ce && pend_r) begin
         mem[addr_r] <= hold_r;  // see R04
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs. Flags decode the counter; each needs one compare, no occupancy adder.
   assign q                  = q_r;  // see R09
   assign flags.empty        = (addr_r == LPS_POS_EMPTY);   // see R14
   assign flags.almost_empty = (addr_r == LPS_POS_AEMPTY);  // see R10
   assign flags.almost_full  = (addr_r == LPS_POS_AFULL);   // see R10
   assign flags.full         = (addr_r == LPS_POS_FULL);    // see R01

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_wr_only;
      ce && go_wr && !go_rd;
   endsequence

   sequence s_rd_only;
      ce && go_rd && !go_wr;
   endsequence

   AST_WR_LOADS: assert property (s_wr_only |=> q_r == $past(req.data)  // see R04
                                  && hold_r == $past(q_r))
      else $error("write did not shift input and output");

   AST_WR_STORES: assert property (s_wr_only ##1 ce |=>  // see R04
                                   mem[$past(addr_r)] == $past(hold_r))
      else $error("holding word not stored after write");

   AST_RD_HOLD: assert property (s_wr_only ##1 s_rd_only |=>  // see R06
                                 q_r == $past(hold_r))
      else $error("read after write not taken from holding");

   AST_RD_DOWN: assert property (s_rd_only |=> addr_r == lps_dn($past(addr_r))  // see R05
                                 && $stable(hold_r))
      else $error("read did not count down");

   AST_BOTH: assert property (ce && go_rd && go_wr |=> q_r == $past(req.data)  // see R07
                              && $stable(hold_r) && $stable(addr_r))
      else $error("read with write changed holding or counter");

   AST_IDLE: assert property (ce && !go_rd && !go_wr && !clr |=>  // see R08
                              $stable(q_r) && $stable(hold_r) && $stable(addr_r))
      else $error("idle cycle changed state");

   AST_CLEAR: assert property (ce && clr |=> flags.empty && !flags.almost_empty  // see R13
                               && q_r == 4'h0 && !pend_r)
      else $error("master reset did not empty stack");

   AST_FLAGS: assert property ($onehot0({flags.full, flags.almost_full,  // see R10
                                         flags.empty, flags.almost_empty})
                               && addr_r != 8'h00)
      else $error("flags overlap or counter in unused state");

   AST_WR_UP: assert property (s_wr_only ##1 s_wr_only |=>  // see R12
                               addr_r == lps_up(lps_up($past(addr_r, 2))))
      else $error("two writes did not advance counter twice");

   ////////////////////////////////////////////////////////////////////////////
   // Further checks on the pending store, the clock enable, the flag steps and the register reads.
   // The pending store is set by every lone push in the tests, but only
   // back-to-back requests read from it, so it is watched from both ends.

   sequence s_both;
      ce && go_rd && go_wr;
   endsequence

   sequence s_quiet;
      ce && !go_rd && !go_wr && !clr;
   endsequence

   sequence s_rd_mem;
      ce && go_rd && !go_wr && !pend_r;
   endsequence

   AST_PEND_SET: assert property (s_wr_only |=> pend_r)  // see R06
      else $error("write did not mark holding as pending");

   AST_PEND_CLR: assert property (s_rd_only |=> !pend_r)  // see R06
      else $error("read left holding marked as pending");

   AST_PEND_BOTH: assert property (s_both |=> !pend_r)  // see R07
      else $error("read with write left holding pending");

   AST_PEND_QUIET: assert property (s_quiet |=> !pend_r)  // see R08
      else $error("idle cycle left holding pending");

   AST_RD_MEM: assert property (s_rd_mem |=> q_r == $past(mem[addr_r]))  // see R06
      else $error("read after non-write not taken from memory");

   AST_WR_UP1: assert property (s_wr_only |=> addr_r == lps_up($past(addr_r)))  // see R04
      else $error("write did not count up");

   // A low enable must freeze everything, including the pending store marker.
   AST_CE_FREEZE: assert property (!ce |=> $stable(q_r) && $stable(hold_r)  // see R02
                                   && $stable(addr_r) && $stable(pend_r)
                                   && $stable(ctrl_r))
      else $error("state moved while clock enable was low");

   // With the enable bit clear, requests must be ignored entirely.
   AST_DISABLED: assert property (ce && !ctrl_r[LPS_CTRL_EN_BIT] && !clr  // see R08
                                  |=> $stable(q_r) && $stable(addr_r)
                                  && $stable(hold_r))
      else $error("disabled stack took a request");

   AST_CLR_ALL: assert property (ce && clr |=> hold_r == LPS_DATA_RESET  // see R13
                                 && addr_r == LPS_POS_EMPTY)
      else $error("clear left holding or counter set");

   AST_AE_STEP: assert property (flags.empty && s_wr_only  // see R10
                                 |=> flags.almost_empty)
      else $error("first push did not raise almost empty");

   AST_AE_DOWN: assert property (flags.almost_empty && s_rd_only  // see R14
                                 |=> flags.empty)
      else $error("last pop did not raise empty");

   AST_AF_STEP: assert property (flags.almost_full && s_wr_only  // see R10
                                 |=> flags.full)
      else $error("push at almost full did not raise full");

   AST_F_DOWN: assert property (flags.full && s_rd_only  // see R14
                                |=> flags.almost_full)
      else $error("pop from full did not raise almost full");

   // The upper bits of every register read are reserved and read as zero.
   AST_RD_UPPER: assert property (psel && penable |-> prdata[31:4] == 28'h0000000)  // see R10
      else $error("register read returned nonzero upper bits");

   AST_ERR_DATA: assert property (psel && penable && !hit  // see R02
                                  |-> prdata == 32'h0000_0000)
      else $error("unmapped read returned data");

   // Bit1 of control is a self-clearing soft reset strobe and must never be kept.
   AST_SRST_SELF: assert property (ce && bus_wr |=> !ctrl_r[LPS_CTRL_SRST_BIT])  // see R13
      else $error("soft reset bit stayed set");

endmodule // lps_stack

// [dv/lps_host_model.sv]
// Behavioural host controller that issues stack requests and honours the flags.
`timescale 1ns/1ns
module lps_host_model
   import lps_pkg::*;
(
   // Wishes from the bench
   input  wire logic                want_wr,
   input  wire logic                want_rd,
   input  wire logic [3:0]          want_data,
   // Stack side
   input  wire lps_pkg::lps_flags_s flags,
   output lps_pkg::lps_req_s        req
);
   // A careful host never pushes into a full stack nor pops an empty one.
   always_comb begin
      req.wr   = want_wr & ~flags.full;
      req.rd   = want_rd & ~flags.empty;
      req.data = want_data;
   end
endmodule // lps_host_model

// [dv/tb_top.sv]
// Self-checking testbench for the push-down stack.
`timescale 1ns/1ns
module tb_top;
   import lps_pkg::*;
   logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
   logic        master_reset, hw, hr, err, en_model;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [3:0]  hd, q;
   lps_req_s    req;
   lps_flags_s  flags;
   int          num_errors, n_compared, depth;
   // The system clock is used here; the host rate limit concerns the pins only.
   always #4 pclk = ~pclk;
   lps_stack DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .master_reset(master_reset), .req(req),
      .q(q), .flags(flags));
   lps_host_model host (.want_wr(hw), .want_rd(hr), .want_data(hd), .flags(flags), .req(req));
   ////////////////////////////////////////////////////////////////////////////
   task results;
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Requests rise after one edge, are taken at the next, then drop for a cycle.
   task op(input logic w, input logic r, input logic [3:0] d, input logic [3:0] eq);
      @(posedge pclk);
      hw <= w;
      hr <= r;
      hd <= d;
      @(posedge pclk);
      hw <= 1'b0;
      hr <= 1'b0;
      @(negedge pclk);
      if (en_model)
         depth = depth + ((w && !r && depth < 254) ? 1 : 0) - ((r && !w && depth > 0) ? 1 : 0);
      chk(q, eq);
      chk(flags, {depth == 254, depth == 253, depth == 0, depth == 1});
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         num_errors++;
         results();
      end
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask
   // Push then pop on consecutive edges, so the pop must come from holding.
   task wr_rd(input logic [3:0] d, input logic [3:0] eq);
      @(posedge pclk);
      hw <= 1'b1;
      hd <= d;
      @(posedge pclk);
      hw <= 1'b0;
      hr <= 1'b1;
      @(posedge pclk);
      hr <= 1'b0;
      @(negedge pclk);
      chk(q, eq);
   endtask
   task t_freeze;
      @(posedge pclk);
      ce <= 1'b0;
      hw <= 1'b1;
      hd <= 4'h8;
      repeat (2) @(posedge pclk);
      hw <= 1'b0;
      @(negedge pclk);
      chk(pready, 1'b0);
      chk(q, 4'h0);
      chk(flags, 4'h2);
      @(posedge pclk);
      ce <= 1'b1;
      op(1, 0, 4'h8, 4'h8);
      $display("freeze done");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task t_walk;
      op(1, 0, 4'h3, 4'h3);
      op(1, 0, 4'h9, 4'h9);
      op(0, 1, 4'h0, 4'h3);
      op(1, 0, 4'h6, 4'h6);
      op(1, 0, 4'ha, 4'ha);
      wr_rd(4'hb, 4'ha);
      op(0, 0, 4'h0, 4'ha);
      op(0, 1, 4'h0, 4'h6);
      op(1, 1, 4'hc, 4'hc);
      op(0, 1, 4'h0, 4'h3);
      op(0, 1, 4'h0, LPS_DATA_RESET);
      $display("walk done");
   endtask
   task t_fill;
      for (int i = 0; i < 254; i++) op(1, 0, i[3:0], i[3:0]);
      op(1, 0, 4'hf, 4'hd);
      for (int i = 252; i >= 0; i--) op(0, 1, 4'h0, i[3:0]);
      op(0, 1, 4'h0, LPS_DATA_RESET);
      $display("fill done");
   endtask
   task t_regs;
      apb(0, 12'h004, 0);
      chk(rdat, 32'h4);
      apb(0, 12'h00c, 0);
      chk({err, rdat}, 33'h1_0000_0000);
      apb(1, 12'h000, 32'h0);
      en_model = 1'b0;
      op(1, 0, 4'h5, 4'h0);
      en_model = 1'b1;
      depth = 0;
      apb(1, 12'h000, 32'h1);
      op(1, 0, 4'h5, 4'h5);
      apb(1, 12'h000, 32'h3);
      depth = 0;
      op(0, 0, 4'h0, 4'h0);
      op(1, 0, 4'h7, 4'h7);
      @(posedge pclk);
      master_reset <= 1'b1;
      @(posedge pclk);
      master_reset <= 1'b0;
      depth = 0;
      op(0, 0, 4'h0, 4'h0);
      $display("regs done");
   endtask
   initial begin
      {pclk, presetn, psel, penable, pwrite, master_reset, hw, hr} = '0;
      {paddr, pwdata, hd} = '0;
      ce = 1'b1;
      num_errors = 0;
      n_compared = 0;
      depth = 0;
      en_model = 1'b1;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk({q, flags}, 8'h02);
      t_walk();
      t_fill();
      t_regs();
      t_freeze();
      results();
   end
endmodule // tb_top
